// ===== rtl/pfs_map.vh
// Register offsets, field positions and pin maps of the port output function select block
`ifndef PFS_MAP_VH
`define PFS_MAP_VH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define PFS_NPORT        7
`define PFS_NPIN         56
`define PFS_PIN_W        8

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define PFS_ADDR_W       12
`define PFS_OFF_PROT     12'h000
`define PFS_PORT_PAGE    4'h1
`define PFS_SEL_PAGE     4'h2
`define PFS_SEL_LAST     8'hdc
`define PFS_KIND_LATCH   2'h0
`define PFS_KIND_DIR     2'h1
`define PFS_KIND_OD      2'h2
`define PFS_KIND_LEVEL   2'h3

// ----------------------------------------
// Fields
// ----------------------------------------
`define PFS_PROT_WE_BIT  2
`define PFS_SEL_ANALOG   7
`define PFS_CODE_PORT    3'h0
`define PFS_CODE_SERIAL  3'h3
`define PFS_CODE_ALT_TX  3'h4
`define PFS_CODE_EVENT   3'h5
`define PFS_SEL_RESET    8'h00
`define PFS_BYTE_RESET   8'h00

// ----------------------------------------
// Pin maps, bit p*8+i is port 9+p pin i
// ----------------------------------------
`define PFS_EXIST_MASK   56'hff78ffff1fffff
`define PFS_ANALOG_MASK  56'hff00000000ff78
`define PFS_F3_MASK      56'hfb00000f0000ff
`define PFS_F4_MASK      56'h20000004000082
`define PFS_F5_MASK      56'hff00ff00000004
`define PFS_OD_PORTS     7'h4d

`endif

// ===== rtl/pfs_pad.v
// One pad: output function multiplexer, direction and open-drain control
`timescale 1ns/1ps
`include "pfs_map.vh"
module pfs_pad (
	code,
	analog,
	dir,
	od,
	latch,
	f3,
	f4,
	f5,
	pad_in,
	pad_o,
	pad_oe,
	periph_in,
	analog_en,
	tol_en
);
	input  wire [2:0] code;
	input  wire       analog;
	input  wire       dir;
	input  wire       od;
	input  wire       latch;
	input  wire       f3;
	input  wire       f4;
	input  wire       f5;
	input  wire       pad_in;
	output reg        pad_o;
	output wire       pad_oe;
	output wire       periph_in;
	output wire       analog_en;
	output wire       tol_en;

	wire drive;

	// ----------------------------------------
	// Output source
	// ----------------------------------------
	// Unassigned codes drive low; the map leaves them undefined
	always @* begin
		case (code)
			`PFS_CODE_PORT:   pad_o = latch;
			`PFS_CODE_SERIAL: pad_o = f3;
			`PFS_CODE_ALT_TX: pad_o = f4;
			`PFS_CODE_EVENT:  pad_o = f5;
			default:          pad_o = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Drivers
	// ----------------------------------------
	// Analog selection overrides the direction bit at the driver only; a stale 1 cannot fight the converter but keeps analog_en low
	assign drive     = dir & ~analog;
	assign pad_oe    = drive & (~od | ~pad_o);
	assign analog_en = analog & ~dir;
	assign periph_in = pad_in;
	assign tol_en    = od;
endmodule // pfs_pad

// ===== rtl/pfs_top.v
// Port 9 to 15 output function select: APB registers, write protection and pad muxes
`timescale 1ns/1ps
`include "pfs_map.vh"

module pfs_top (
	clk,
	rst,
	ce,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	prdata,
	pready,
	pslverr,
	periph_f3,
	periph_f4,
	periph_f5,
	pad_in,
	pad_o,
	pad_oe,
	periph_in,
	analog_en,
	tol_en,
	key_in
);
	input  wire                    clk;
	input  wire                    rst;
	input  wire                    ce;
	input  wire                    psel;
	input  wire                    penable;
	input  wire                    pwrite;
	input  wire [`PFS_ADDR_W-1:0]  paddr;
	input  wire [31:0]             pwdata;
	output reg  [31:0]             prdata;
	output wire                    pready;
	output reg                     pslverr;
	input  wire [`PFS_NPIN-1:0]    periph_f3;
	input  wire [`PFS_NPIN-1:0]    periph_f4;
	input  wire [`PFS_NPIN-1:0]    periph_f5;
	input  wire [`PFS_NPIN-1:0]    pad_in;
	output wire [`PFS_NPIN-1:0]    pad_o;
	output wire [`PFS_NPIN-1:0]    pad_oe;
	output wire [`PFS_NPIN-1:0]    periph_in;
	output wire [`PFS_NPIN-1:0]    analog_en;
	output wire [`PFS_NPIN-1:0]    tol_en;
	output wire [`PFS_PIN_W-1:0]   key_in;

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg  [7:0]               sel_r [0:`PFS_NPIN-1];
	reg  [`PFS_PIN_W-1:0]    latch_r [0:`PFS_NPORT-1];
	reg  [`PFS_PIN_W-1:0]    dir_r [0:`PFS_NPORT-1];
	reg  [`PFS_PIN_W-1:0]    od_r [0:`PFS_NPORT-1];
	reg                      we_r;
	reg                      we_nxt;
	reg  [31:0]              rd_nxt;
	reg                      err_nxt;

	wire [`PFS_NPIN-1:0]     exist_m;
	wire [`PFS_NPIN-1:0]     analog_m;
	wire [`PFS_NPORT-1:0]    od_ports;
	wire [`PFS_NPIN-1:0]     f3_m;
	wire [`PFS_NPIN-1:0]     f4_m;
	wire [`PFS_NPIN-1:0]     f5_m;
	wire [`PFS_NPIN-1:0]     lat_flat;
	wire [`PFS_NPIN-1:0]     dir_flat;
	wire [`PFS_NPIN-1:0]     od_flat;

	wire                     setup;
	wire                     access;
	wire                     is_prot;
	wire                     is_port;
	wire                     is_sel;
	wire [2:0]               port_idx;
	wire [1:0]               kind;
	wire [5:0]               sel_idx;
	wire                     sel_ok;
	wire [`PFS_PIN_W-1:0]    port_level;

	integer                  k;

	assign exist_m  = `PFS_EXIST_MASK;
	assign analog_m = `PFS_ANALOG_MASK;
	assign od_ports = `PFS_OD_PORTS;
	// Codes outside the per-pin map see no peripheral signal at all
	assign f3_m     = periph_f3 & `PFS_F3_MASK;
	assign f4_m     = periph_f4 & `PFS_F4_MASK;
	assign f5_m     = periph_f5 & `PFS_F5_MASK;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	assign setup    = psel & ~penable;
	assign access   = psel & penable;
	assign pready   = 1'b1;
	assign is_prot  = (paddr == `PFS_OFF_PROT);
	assign port_idx = paddr[6:4];
	assign kind     = paddr[3:2];
	assign is_port  = (paddr[11:8] == `PFS_PORT_PAGE) && (paddr[7] == 1'b0)
			&& (port_idx < `PFS_NPORT) && (paddr[1:0] == 2'b00);
	assign sel_idx  = paddr[7:2];
	assign is_sel   = (paddr[11:8] == `PFS_SEL_PAGE) && (paddr[7:0] <= `PFS_SEL_LAST)
			&& (paddr[1:0] == 2'b00) && exist_m[sel_idx];
	assign sel_ok   = is_sel & we_r;
	assign port_level = pad_in[port_idx*8 +: 8];

	// ----------------------------------------
	// Read data, captured in the setup cycle
	// ----------------------------------------
	always @* begin
		rd_nxt  = 32'h00000000;
		err_nxt = 1'b0;
		if (is_prot) begin
			rd_nxt[`PFS_PROT_WE_BIT] = we_r;
		end else if (is_port) begin
			case (kind)
				`PFS_KIND_LATCH: rd_nxt[7:0] = latch_r[port_idx];
				`PFS_KIND_DIR:   rd_nxt[7:0] = dir_r[port_idx];
				`PFS_KIND_OD:    rd_nxt[7:0] = od_r[port_idx];
				default:         rd_nxt[7:0] = port_level;
			endcase
		end else if (is_sel) begin
			rd_nxt[7:0] = sel_r[sel_idx];
		end else begin
			err_nxt = 1'b1;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (ce && setup) begin
			prdata  <= rd_nxt;
			pslverr <= err_nxt;
		end
	end

	// ----------------------------------------
	// Write protection
	// ----------------------------------------
	// The enable survives exactly one further transfer, so an intervening access
	// from an interrupt or DMA relocks the selects
	always @* begin
		we_nxt = we_r;
		if (access) begin
			if (is_prot && pwrite)
				we_nxt = pwdata[`PFS_PROT_WE_BIT];
			else
				we_nxt = 1'b0;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst)
			we_r <= 1'b0;
		else if (ce)
			we_r <= we_nxt;
	end

	// ----------------------------------------
	// Select, latch, direction and open-drain registers
	// ----------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			for (k = 0; k < `PFS_NPIN; k = k + 1)
				sel_r[k] <= `PFS_SEL_RESET;
			for (k = 0; k < `PFS_NPORT; k = k + 1) begin
				latch_r[k] <= `PFS_BYTE_RESET;
				dir_r[k]   <= `PFS_BYTE_RESET;
				od_r[k]    <= `PFS_BYTE_RESET;
			end
		end else if (ce && access && pwrite) begin
			if (sel_ok) begin
				// Only the code field and, where a converter exists, the analog bit are kept
				sel_r[sel_idx] <= {pwdata[`PFS_SEL_ANALOG] & analog_m[sel_idx],
					4'h0, pwdata[2:0]};
			end
			if (is_port) begin
				case (kind)
					`PFS_KIND_LATCH: latch_r[port_idx] <= pwdata[7:0];
					`PFS_KIND_DIR:   dir_r[port_idx]   <= pwdata[7:0];
					`PFS_KIND_OD:    od_r[port_idx]    <= pwdata[7:0]
						& {8{od_ports[port_idx]}};
					default:         latch_r[port_idx] <= latch_r[port_idx];
				endcase
			end
		end
	end

	// ----------------------------------------
	// Pads
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < `PFS_NPIN; g = g + 1) begin : g_pad
			wire present;

			assign present     = exist_m[g];
			assign lat_flat[g] = latch_r[g/8][g%8] & present;
			assign dir_flat[g] = dir_r[g/8][g%8] & present;
			assign od_flat[g]  = od_r[g/8][g%8] & present;

			pfs_pad u_pad (
				.code      (sel_r[g][2:0]),
				.analog    (sel_r[g][`PFS_SEL_ANALOG]),
				.dir       (dir_flat[g]),
				.od        (od_flat[g]),
				.latch     (lat_flat[g]),
				.f3        (f3_m[g]),
				.f4        (f4_m[g]),
				.f5        (f5_m[g]),
				.pad_in    (pad_in[g]),
				.pad_o     (pad_o[g]),
				.pad_oe    (pad_oe[g]),
				.periph_in (periph_in[g]),
				.analog_en (analog_en[g]),
				.tol_en    (tol_en[g])
			);
		end
	endgenerate

	// Key input interrupt sees port 10 pad level whatever the selection
	assign key_in = pad_in[15:8];
endmodule // pfs_top

// ===== testbench/pfs_monitor.sv
// Port-level checker for the port output function select block
`timescale 1ns/1ps
`include "pfs_map.vh"
module pfs_monitor (
	input wire                   clk,
	input wire                   rst,
	input wire                   ce,
	input wire                   psel,
	input wire                   penable,
	input wire                   pwrite,
	input wire [`PFS_ADDR_W-1:0] paddr,
	input wire [31:0]            pwdata,
	input wire [31:0]            prdata,
	input wire                   pready,
	input wire                   pslverr,
	input wire [`PFS_NPIN-1:0]   periph_f3,
	input wire [`PFS_NPIN-1:0]   periph_f4,
	input wire [`PFS_NPIN-1:0]   periph_f5,
	input wire [`PFS_NPIN-1:0]   pad_in,
	input wire [`PFS_NPIN-1:0]   pad_o,
	input wire [`PFS_NPIN-1:0]   pad_oe,
	input wire [`PFS_NPIN-1:0]   periph_in,
	input wire [`PFS_NPIN-1:0]   analog_en,
	input wire [`PFS_NPIN-1:0]   tol_en,
	input wire [`PFS_PIN_W-1:0]  key_in
);
	// ----------------------------------------
	// Pad relations
	// ----------------------------------------
	// Ports 9, 11, 12 and 15 are the only ones with an open-drain bit
	localparam [55:0] OD_PINS = 56'hff0000ffff00ff;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	chk_analog_undriven: assert property ((analog_en & pad_oe) == 0)
		else $error("analog pin is driven");
	chk_analog_pins: assert property ((analog_en & ~`PFS_ANALOG_MASK) == 0)
		else $error("analog enable on a digital pin");
	chk_exist_only: assert property ((pad_oe & ~`PFS_EXIST_MASK) == 0)
		else $error("missing pin driven");
	chk_od_high_side: assert property ((tol_en & pad_oe & pad_o) == 0)
		else $error("open-drain pin drives high");
	chk_od_ports: assert property ((tol_en & ~OD_PINS) == 0)
		else $error("open-drain bit on a port without one");
	chk_periph_pad: assert property (periph_in == pad_in)
		else $error("peripheral input differs from pad");
	chk_key_pad: assert property ($changed(pad_in[15:8]) |-> key_in == pad_in[15:8])
		else $error("key input differs from pad");
	chk_reset_quiet: assert property ($fell(rst) |-> pad_oe == 0 && analog_en == 0)
		else $error("pad active after reset");
	chk_unmapped_err: assert property (psel && !penable && ce && paddr == 12'hffc
		##1 psel && penable |-> pslverr)
		else $error("no error on unmapped access");
endmodule // pfs_monitor
bind pfs_top pfs_monitor pfs_monitor_i (.clk, .rst, .ce, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .periph_f3, .periph_f4, .periph_f5, .pad_in,
	.pad_o, .pad_oe, .periph_in, .analog_en, .tol_en, .key_in);

// ===== testbench/pfs_tb.sv
// Self-checking testbench for the port output function select block
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
	$display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module testbench;
	logic        clk, rst, ce, psel, penable, pwrite, err, b;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	logic [55:0] periph_f3, periph_f4, periph_f5, pad_in, dirm;
	logic [2:0]  c;
	wire  [31:0] prdata;
	wire         pready, pslverr;
	wire  [55:0] pad_o, pad_oe, periph_in, analog_en, tol_en;
	wire  [7:0]  key_in;
	int          failures, comparisons, cyc, p;
	int          pins [9] = '{2, 1, 2, 24, 26, 38, 48, 53, 55};
	int          apins [3] = '{3, 8, 49};
	pfs_top pfs_top_i (.clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .periph_f3, .periph_f4, .periph_f5, .pad_in, .pad_o, .pad_oe,
		.periph_in, .analog_en, .tol_en, .key_in);
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task apb(input logic w, input int a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a[11:0];
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Unlock and select write back to back, as software must do it
	task wsel(input int a, input logic [7:0] v);
		apb(1'b1, 0, 32'h4);
		apb(1'b1, a, {24'h0, v});
	endtask
	task report_and_stop;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	always #5 clk = ~clk;
	// Well above the few hundred cycles the sequence needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			report_and_stop;
		end
	end
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		{clk, psel, penable, pwrite, paddr, pwdata, periph_f3, periph_f4, periph_f5} = '0;
		rst = 1'b1;
		ce = 1'b1;
		pad_in = 56'h0f1e2d3c4b5a69;
		dirm = '0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		#1 `CHK("oe after reset", 56'h0, pad_oe)
		apb(1'b0, 12'h208, 0);
		`CHK("select reset", 32'h0, rd)
		apb(1'b1, 12'h20c, 32'h3);
		apb(1'b0, 12'h20c, 0);
		`CHK("locked write", 32'h0, rd)
		apb(1'b1, 0, 32'h4);
		apb(1'b0, 12'h100, 0);
		apb(1'b1, 12'h20c, 32'h3);
		apb(1'b0, 12'h20c, 0);
		`CHK("consumed unlock", 32'h0, rd)
		apb(1'b1, 0, 32'h4);
		apb(1'b0, 0, 0);
		`CHK("unlock bit", 32'h4, rd)
		for (int k = 0; k < 9; k++) begin
			p = pins[k];
			c = 3'(3 + k % 3);
			wsel(12'h200 + p * 4, {5'h0, c});
			dirm[p] = 1'b1;
			apb(1'b1, 12'h104 + (p / 8) * 16, {24'h0, dirm[(p / 8) * 8 +: 8]});
			apb(1'b0, 12'h200 + p * 4, 0);
			`CHK("select code", {29'h0, c}, rd)
			b = 1'b0;
			repeat (2) begin
				@(posedge clk);
				periph_f3 <= {56{(c == 3'h3) ? b : ~b}};
				periph_f4 <= {56{(c == 3'h4) ? b : ~b}};
				periph_f5 <= {56{(c == 3'h5) ? b : ~b}};
				#1 `CHK("pad value", b, pad_o[p])
				`CHK("pad drive", 1'b1, pad_oe[p])
				b = ~b;
			end
		end
		wsel(12'h208, 8'h00);
		apb(1'b1, 12'h100, 32'h4);
		#1 `CHK("latch value", 1'b1, pad_o[2])
		apb(1'b1, 12'h108, 32'h4);
		#1 `CHK("od high", 1'b0, pad_oe[2])
		`CHK("tolerant", 1'b1, tol_en[2])
		apb(1'b1, 12'h100, 0);
		#1 `CHK("od low", 1'b1, pad_oe[2] & ~pad_o[2])
		dirm[2] = 1'b0;
		apb(1'b1, 12'h104, {24'h0, dirm[7:0]});
		#1 `CHK("input pin", 1'b0, pad_oe[2])
		// A write while the clock enable is low must not land
		@(posedge clk);
		ce <= 1'b0;
		apb(1'b1, 12'h100, 32'hff);
		ce <= 1'b1;
		apb(1'b0, 12'h100, 0);
		`CHK("frozen write", 32'h0, rd)
		apb(1'b1, 12'h168, 32'h1);
		@(posedge clk);
		periph_f3 <= '1;
		#1 `CHK("od p15", 2'b01, {pad_oe[48], tol_en[48]})
		apb(1'b1, 12'h148, 32'hff);
		apb(1'b0, 12'h148, 0);
		`CHK("no od p13", 32'h0, rd)
		foreach (apins[k]) begin
			wsel(12'h200 + apins[k] * 4, 8'h80);
			apb(1'b0, 12'h200 + apins[k] * 4, 0);
			`CHK("analog select", 32'h80, rd)
			`CHK("analog pin", 2'b10, {analog_en[apins[k]], pad_oe[apins[k]]})
		end
		apb(1'b0, 12'hffc, 0);
		`CHK("unmapped", 1'b1, err)
		apb(1'b1, 12'h254, 32'h3);
		`CHK("missing pin", 1'b1, err)
		apb(1'b0, 12'h10c, 0);
		`CHK("pad level", {24'h0, pad_in[7:0]}, rd)
		apb(1'b0, 12'h2ac, 0);
		`CHK("port 14 select", 32'h0, rd)
		@(posedge clk);
		pad_in <= ~pad_in;
		#1 `CHK("pad to periph", pad_in, periph_in)
		`CHK("key input", pad_in[15:8], key_in)
		report_and_stop;
	end
endmodule // testbench
